/* File: rtl/rswd_pkg.sv */
// Constants for the reset and watchdog supervisor.
// Assumes a 20 MHz core clock and the plain register port.
package rswd_pkg;
    localparam int CLK_HZ = 20000000;
    localparam int CLK_PER_MS = CLK_HZ / 1000;
    localparam int CLK_PER_US = CLK_HZ / 1000000;
    localparam int RF_US = 10;
    localparam int RF_CYC = RF_US * CLK_PER_US;
    localparam int RD_MS = 10;
    localparam int LW_MS = 200;
    localparam int CLOSED_NUM = 3;
    localparam int CLOSED_DEN = 5;
    localparam logic [1:0] ADDR_MODE = 2'h0;
    localparam logic [1:0] ADDR_WDCTL = 2'h1;
    localparam logic [1:0] ADDR_STAT = 2'h2;
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_SLEEP = 2'h1;
    localparam logic [1:0] MODE_STOP = 2'h2;
    localparam logic [1:0] MODE_SOFT = 2'h3;
    localparam int MB_PULSE = 2;
    localparam int WB_TYPE = 4;
    localparam int WB_RSVD = 3;
    localparam int SB_SERR = 2;
    localparam int SB_RO = 6;
    localparam logic [2:0] PER_RST = 3'h1;
    localparam logic [1:0] CFG_TWO = 2'h1;
    localparam logic [1:0] SAT_CFG2 = 2'h1;
    localparam logic [1:0] SAT_OTHER = 2'h2;
    typedef enum logic [2:0] {
        ST_INIT = 3'h0,
        ST_NORMAL = 3'h1,
        ST_RESTART = 3'h3,
        ST_FAILSAFE = 3'h2,
        ST_STOP = 3'h6,
        ST_SLEEP = 3'h7
    } rswd_mode_e;
    typedef enum logic [1:0] {
        WD_OFF = 2'h0,
        WD_LONG = 2'h1,
        WD_CLOSED = 2'h3,
        WD_OPEN = 2'h2
    } rswd_wd_e;
endpackage

/* File: rtl/rswd_top.sv */
// Reset output and watchdog supervisor with a plain register port.
// Assumes synchronous inputs and a 20 MHz clock on clk.
`timescale 1ns/1ps
`default_nettype none
module rswd_top
    import rswd_pkg::*;
#(
    parameter int TICK_CYC = CLK_PER_MS,
    parameter int RD_TIME_MS = RD_MS,
    parameter int LW_TIME_MS = LW_MS
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wrStb,
    input wire logic rdStb,
    output logic [7:0] rdata,
    input wire logic supplyLow,
    input wire logic devMode,
    input wire logic [1:0] failConfig,
    output logic resetOutPin,
    output logic failOut,
    output logic [2:0] sbcMode
);
    function automatic logic [9:0] periodMs(input logic [2:0] code);
        unique case (code)
            3'h2: periodMs = 10'h014;
            3'h3: periodMs = 10'h032;
            3'h4: periodMs = 10'h064;
            3'h5: periodMs = 10'h0c8;
            3'h6: periodMs = 10'h1f4;
            3'h7: periodMs = 10'h3e8;
            default: periodMs = 10'h00a;
        endcase
    endfunction

    logic [15:0] divCnt_q, divCnt_d;
    logic msTick;
    always_comb begin
        msTick = (divCnt_q == 16'(TICK_CYC - 1));
        divCnt_d = msTick ? 16'h0000 : divCnt_q + 16'h0001;
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            divCnt_q <= 16'h0000;
        end else begin
            divCnt_q <= divCnt_d;
        end
    end

    rswd_mode_e mode_q, mode_d;
    rswd_wd_e wdSt_q, wdSt_d;
    logic [9:0] wdCnt_q, wdCnt_d;
    logic [9:0] dlyCnt_q, dlyCnt_d;
    logic [7:0] fltCnt_q, fltCnt_d;
    logic roHigh_q, roHigh_d;
    logic roLow_q, roLow_d;
    logic wdType_q, wdType_d;
    logic [2:0] period_q, period_d;
    logic pulseSel_q, pulseSel_d;
    logic [1:0] failCnt_q, failCnt_d;
    logic serErr_q, serErr_d;
    logic failOut_q, failOut_d;
    logic [7:0] rdata_q, rdata_d;
    logic trig, parOk, goodTrig, wdFire, runWd, softRst, vccFilt;
    logic [9:0] perMs, closedMs;
    logic [1:0] failMax;

    always_comb begin
        mode_d = mode_q;
        wdSt_d = wdSt_q;
        wdCnt_d = wdCnt_q;
        dlyCnt_d = dlyCnt_q;
        fltCnt_d = fltCnt_q;
        roLow_d = roLow_q;
        wdType_d = wdType_q;
        period_d = period_q;
        pulseSel_d = pulseSel_q;
        failCnt_d = failCnt_q;
        serErr_d = serErr_q;
        failOut_d = failOut_q;
        perMs = periodMs(period_q);
        closedMs = 10'((32'(perMs) * CLOSED_NUM) / CLOSED_DEN);
        failMax = (failConfig == CFG_TWO) ? SAT_CFG2 : SAT_OTHER;
        trig = wrStb && (addr == ADDR_WDCTL);
        // Even parity over all eight bits
        parOk = ~^wdata;
        runWd = !devMode && (wdSt_q != WD_OFF);
        goodTrig = trig && parOk && runWd && (wdSt_q != WD_CLOSED);
        wdFire = 1'b0;
        vccFilt = supplyLow && (fltCnt_q == 8'(RF_CYC - 1));
        fltCnt_d = !supplyLow ? 8'h00 : (vccFilt ? fltCnt_q : fltCnt_q + 8'h01);
        // Bad parity flagged, set wins over clear
        if (wrStb && addr == ADDR_STAT && wdata[SB_SERR]) begin
            serErr_d = 1'b0;
        end
        if (trig && !parOk) begin
            serErr_d = 1'b1;
        end
        // Watchdog timing
        if (runWd && msTick) begin
            wdCnt_d = wdCnt_q + 10'h001;
            unique case (wdSt_q)
                WD_LONG: wdFire = (wdCnt_q + 10'h001 >= 10'(LW_TIME_MS));
                WD_CLOSED: begin
                    if (wdCnt_q + 10'h001 >= closedMs) begin
                        wdSt_d = WD_OPEN;
                    end
                end
                WD_OPEN: wdFire = (wdCnt_q + 10'h001 >= perMs);
                default: ;
            endcase
        end
        if (trig && parOk && runWd && wdSt_q == WD_CLOSED) begin
            wdFire = 1'b1;
        end
        if (goodTrig) begin
            wdCnt_d = 10'h000;
            failCnt_d = 2'h0;
            // Type bit, settings only taken in Normal
            if (mode_q == ST_NORMAL) begin
                wdType_d = wdata[WB_TYPE];
                period_d = wdata[2:0];
            end
            // Time-out type opens a full period
            wdSt_d = (mode_q == ST_NORMAL ? wdata[WB_TYPE] : wdType_q) ? WD_CLOSED : WD_OPEN;
        end
        if (wdFire) begin
            failCnt_d = (failCnt_q >= failMax) ? failMax : failCnt_q + 2'h1;
            // Repeated failure at saturation goes Fail-Safe
            mode_d = (failCnt_q == failMax) ? ST_FAILSAFE : ST_RESTART;
            // First failure under config 2 is silent
            if (!(failConfig == CFG_TWO && failCnt_q == 2'h0)) begin
                failOut_d = 1'b1;
            end
            wdSt_d = WD_OFF;
            wdCnt_d = 10'h000;
        end
        // Mode commands
        softRst = 1'b0;
        if (wrStb && addr == ADDR_MODE && !wdFire) begin
            if (wdata[1:0] == MODE_SOFT) begin
                softRst = (mode_q == ST_NORMAL) || (mode_q == ST_STOP);
                pulseSel_d = wdata[MB_PULSE];
            end else if (mode_q == ST_INIT || mode_q == ST_NORMAL || mode_q == ST_STOP) begin
                pulseSel_d = wdata[MB_PULSE];
                unique case (wdata[1:0])
                    MODE_SLEEP: mode_d = ST_SLEEP;
                    MODE_STOP: mode_d = ST_STOP;
                    default: begin
                        // Long window on exit from Sleep; never reached, since mode commands are ignored in Sleep
                        if (mode_q == ST_SLEEP) begin
                            wdSt_d = WD_LONG;
                            wdCnt_d = 10'h000;
                        end
                        mode_d = ST_NORMAL;
                    end
                endcase
            end
        end
        // Sleep turns the watchdog off, and clears the failure count
        if (mode_d == ST_SLEEP) begin
            wdSt_d = WD_OFF;
            failCnt_d = 2'h0;
        end
        // Soft reset restores defaults and Init
        if (softRst) begin
            mode_d = ST_INIT;
            wdType_d = 1'b0;
            period_d = PER_RST;
            failCnt_d = 2'h0;
            serErr_d = 1'b0;
            failOut_d = 1'b0;
            wdSt_d = WD_OFF;
            wdCnt_d = 10'h000;
            // Kept pulse select, so the current write steers the pin
        end
        // Reset pin low hold and delay
        if (vccFilt || wdFire || (softRst && wdata[MB_PULSE])) begin
            // Soft reset pulses the pin only when selected
            roLow_d = 1'b1;
            dlyCnt_d = 10'h000;
        end else if (roLow_q && supplyLow) begin
            dlyCnt_d = 10'h000;
        end else if (roLow_q && msTick) begin
            // Release after the delay, also at power-up
            if (dlyCnt_q + 10'h001 >= 10'(RD_TIME_MS)) begin
                roLow_d = 1'b0;
                if (mode_q != ST_FAILSAFE && mode_q != ST_SLEEP) begin
                    wdSt_d = WD_LONG;
                    wdCnt_d = 10'h000;
                end
                if (mode_q == ST_RESTART) begin
                    mode_d = ST_NORMAL;
                end
            end else begin
                dlyCnt_d = dlyCnt_q + 10'h001;
            end
        end
        // Watchdog stays off while the pin is held low
        if (roLow_d) begin
            wdSt_d = WD_OFF;
        end
        roHigh_d = !roLow_d;
        rdata_d = 8'h00;
        if (rdStb) begin
            unique case (addr)
                ADDR_MODE: rdata_d = {5'h00, pulseSel_q, 2'h0};
                // Reserved bit reads as zero
                ADDR_WDCTL: rdata_d = {3'h0, wdType_q, 1'b0, period_q};
                ADDR_STAT: rdata_d = {1'b0, roHigh_q, mode_q, serErr_q, failCnt_q};
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= ST_INIT;
            wdSt_q <= WD_OFF;
            wdCnt_q <= 10'h000;
            dlyCnt_q <= 10'h000;
            fltCnt_q <= 8'h00;
            roLow_q <= 1'b1;
            roHigh_q <= 1'b0;
            wdType_q <= 1'b0;
            period_q <= PER_RST;
            pulseSel_q <= 1'b1;
            failCnt_q <= 2'h0;
            serErr_q <= 1'b0;
            failOut_q <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            mode_q <= mode_d;
            wdSt_q <= wdSt_d;
            wdCnt_q <= wdCnt_d;
            dlyCnt_q <= dlyCnt_d;
            fltCnt_q <= fltCnt_d;
            roLow_q <= roLow_d;
            roHigh_q <= roHigh_d;
            wdType_q <= wdType_d;
            period_q <= period_d;
            pulseSel_q <= pulseSel_d;
            failCnt_q <= failCnt_d;
            serErr_q <= serErr_d;
            failOut_q <= failOut_d;
            rdata_q <= rdata_d;
        end
    end

    assign rdata = rdata_q;
    assign resetOutPin = roHigh_q;
    assign failOut = failOut_q;
    assign sbcMode = mode_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_soft_ignored: assert property (
        wrStb && addr == ADDR_MODE && wdata[1:0] == MODE_SOFT && !wdFire
        && mode_q != ST_NORMAL && mode_q != ST_STOP |=> $stable(mode_q))
        else $error("soft reset taken outside Normal or Stop");
    a_soft_init: assert property (
        softRst |=> mode_q == ST_INIT && failCnt_q == 2'h0 && period_q == PER_RST)
        else $error("soft reset did not restore defaults");
    a_parity_reject: assert property (
        trig && !parOk |=> serErr_q && $stable(period_q) && $stable(wdType_q))
        else $error("bad parity write not rejected");
    a_stop_frozen: assert property (
        mode_q == ST_STOP && !softRst |=> $stable(period_q) && $stable(wdType_q))
        else $error("watchdog settings changed in Stop");
    a_fire_pin_low: assert property (
        wdFire |=> !resetOutPin ##1 !resetOutPin)
        else $error("watchdog failure did not drop the reset pin");
    a_dev_quiet: assert property (
        devMode |-> !wdFire)
        else $error("watchdog fired in development mode");
    a_closed_hit: assert property (
        trig && parOk && runWd && wdSt_q == WD_CLOSED
        |=> !resetOutPin && (mode_q == ST_RESTART || mode_q == ST_FAILSAFE))
        else $error("closed window trigger not punished");
    a_fail_sat: assert property (
        failCnt_q <= failMax || $changed(failConfig))
        else $error("failure counter above its ceiling");
    a_good_clear: assert property (
        goodTrig && !wdFire |=> failCnt_q == 2'h0 && wdCnt_q == 10'h000)
        else $error("good trigger did not clear the counter");
    a_restart_long: assert property (
        $rose(resetOutPin) && $past(mode_q) == ST_RESTART
        |-> mode_q == ST_NORMAL && wdSt_q == WD_LONG)
        else $error("no Normal entry with long window after restart");
    a_filter_time: assert property (
        $rose(supplyLow) && resetOutPin |=> resetOutPin [*8])
        else $error("reset pin dropped before the filter time");
endmodule
`default_nettype wire

/* File: test/rswd_host.sv */
// Host microcontroller model: register port master serving the watchdog.
// Assumes the supervisor takes strobes on the rising edge of clk.
`timescale 1ns/1ps
`default_nettype none
module rswd_host (
    input wire logic clk,
    input wire logic [7:0] rdata,
    output logic [1:0] addr,
    output logic [7:0] wdata,
    output logic wrStb,
    output logic rdStb
);
    initial begin
        addr = 2'h3;
        wdata = 8'h00;
        wrStb = 1'b0;
        rdStb = 1'b0;
    end

    function automatic logic [7:0] ctlByte(input logic win, input logic [2:0] per,
                                           input logic rsv);
        logic [6:0] b;
        b = {2'h0, win, rsv, per};
        return {^b, b};
    endfunction

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wrStb <= 1'b1;
        @(posedge clk);
        wrStb <= 1'b0;
        // Released data no longer shows the last value
        wdata <= ~d;
    endtask

    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rdStb <= 1'b1;
        @(posedge clk);
        rdStb <= 1'b0;
        #1 d = rdata;
    endtask
endmodule
`default_nettype wire

/* File: test/test_rswd_top.sv */
// Self-checking bench for the reset and watchdog supervisor.
// Assumes the host model owns the register port; ms ticks shrunk to 20 cycles.
`timescale 1ns/1ps
`default_nettype none
module test_rswd_top
    import rswd_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic supplyLow = 1'b0;
    logic devMode = 1'b0;
    logic [1:0] failConfig = 2'h0;
    wire logic [1:0] addr;
    wire logic [7:0] wdata;
    wire logic wrStb;
    wire logic rdStb;
    logic [7:0] rdata;
    logic resetOutPin;
    logic failOut;
    logic [2:0] sbcMode;
    int mismatches = 0;
    int tests_run = 0;
    int cycles = 0;

    always #25 clk = ~clk;

    rswd_top #(.TICK_CYC(20), .RD_TIME_MS(2), .LW_TIME_MS(5)) dut (
        .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wrStb(wrStb),
        .rdStb(rdStb), .rdata(rdata), .supplyLow(supplyLow), .devMode(devMode),
        .failConfig(failConfig), .resetOutPin(resetOutPin), .failOut(failOut),
        .sbcMode(sbcMode));
    rswd_host host (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata),
        .wrStb(wrStb), .rdStb(rdStb));

    task automatic results();
        $display("Checks run %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic chkMode(input rswd_mode_e e);
        cyc(2);
        chk({5'h0, sbcMode}, {5'h0, e});
    endtask

    task automatic chkPin(input logic p, input logic f);
        chk({6'h0, failOut, resetOutPin}, {6'h0, f, p});
    endtask

    task automatic rdChk(input logic [1:0] a, input logic [7:0] m, input logic [7:0] e);
        logic [7:0] d;
        host.rd(a, d);
        chk(d & m, e);
    endtask

    // Bounded wait for the pin level, then its timing window
    task automatic waitPin(input logic v, input int lo, input int hi);
        int n;
        n = 0;
        while (resetOutPin !== v && n < hi) begin
            @(posedge clk);
            n++;
        end
        chk({7'h0, resetOutPin}, {7'h0, v});
        chk({7'h0, n >= lo}, 8'h01);
    endtask

    task automatic trig(input logic win, input logic [2:0] per);
        host.wr(ADDR_WDCTL, host.ctlByte(win, per, 1'b0));
    endtask

    task automatic porReset();
        rst_n <= 1'b0;
        cyc(6);
        rst_n <= 1'b1;
    endtask

    // Whole run is near 2700 cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 9000) begin
            mismatches++;
            results();
        end
    end

    initial begin
        porReset();
        chkPin(1'b0, 1'b0);
        waitPin(1'b1, 35, 70);
        rdChk(ADDR_STAT, 8'h7f, 8'h40);
        rdChk(ADDR_WDCTL, 8'h1f, {5'h0, PER_RST});
        host.wr(2'h3, 8'hff);
        rdChk(2'h3, 8'hff, 8'h00);
        host.wr(ADDR_MODE, 8'h04);
        chkMode(ST_NORMAL);
        host.wr(ADDR_WDCTL, host.ctlByte(1'b1, 3'h2, 1'b0) ^ 8'h80);
        rdChk(ADDR_STAT, 8'h04, 8'h04);
        rdChk(ADDR_WDCTL, 8'h1f, 8'h01);
        host.wr(ADDR_STAT, 8'h04);
        rdChk(ADDR_STAT, 8'h04, 8'h00);
        host.wr(ADDR_WDCTL, host.ctlByte(1'b0, 3'h1, 1'b1));
        rdChk(ADDR_WDCTL, 8'h1f, 8'h01);
        rdChk(ADDR_STAT, 8'h04, 8'h00);
        for (int i = 0; i < 4; i++) begin
            cyc(170);
            trig(1'b0, 3'h1);
        end
        chkPin(1'b1, 1'b0);
        for (int p = 7; p >= 1; p--) begin
            trig(1'b0, p[2:0]);
            rdChk(ADDR_WDCTL, 8'h1f, {5'h0, p[2:0]});
        end
        waitPin(1'b0, 178, 240);
        chkMode(ST_RESTART);
        chkPin(1'b0, 1'b1);
        rdChk(ADDR_STAT, 8'h03, 8'h01);
        waitPin(1'b1, 15, 70);
        chkMode(ST_NORMAL);
        trig(1'b1, 3'h1);
        rdChk(ADDR_STAT, 8'h03, 8'h00);
        cyc(150);
        trig(1'b1, 3'h1);
        chkPin(1'b1, 1'b1);
        cyc(50);
        trig(1'b1, 3'h1);
        waitPin(1'b0, 0, 10);
        rdChk(ADDR_STAT, 8'h03, 8'h01);
        waitPin(1'b1, 15, 70);
        chkMode(ST_NORMAL);
        host.wr(ADDR_MODE, 8'h03);
        chkMode(ST_INIT);
        chkPin(1'b1, 1'b0);
        rdChk(ADDR_WDCTL, 8'h1f, 8'h01);
        host.wr(ADDR_MODE, 8'h04);
        trig(1'b0, 3'h1);
        host.wr(ADDR_MODE, 8'h07);
        waitPin(1'b0, 0, 10);
        waitPin(1'b1, 15, 70);
        chkMode(ST_INIT);
        host.wr(ADDR_MODE, 8'h04);
        trig(1'b0, 3'h1);
        host.wr(ADDR_MODE, 8'h06);
        chkMode(ST_STOP);
        trig(1'b1, 3'h3);
        rdChk(ADDR_WDCTL, 8'h1f, 8'h01);
        host.wr(ADDR_MODE, 8'h04);
        trig(1'b0, 3'h1);
        failConfig <= CFG_TWO;
        waitPin(1'b0, 178, 240);
        chkMode(ST_RESTART);
        chkPin(1'b0, 1'b0);
        waitPin(1'b1, 15, 70);
        waitPin(1'b0, 90, 140);
        chkMode(ST_FAILSAFE);
        chkPin(1'b0, 1'b1);
        rdChk(ADDR_STAT, 8'h03, {6'h0, SAT_CFG2});
        host.wr(ADDR_MODE, 8'h03);
        chkMode(ST_FAILSAFE);
        devMode <= 1'b1;
        failConfig <= 2'h0;
        porReset();
        waitPin(1'b1, 35, 70);
        host.wr(ADDR_MODE, 8'h04);
        cyc(400);
        chkPin(1'b1, 1'b0);
        chkMode(ST_NORMAL);
        supplyLow <= 1'b1;
        cyc(150);
        supplyLow <= 1'b0;
        cyc(20);
        chkPin(1'b1, 1'b0);
        supplyLow <= 1'b1;
        waitPin(1'b0, 195, 215);
        cyc(100);
        chkPin(1'b0, 1'b0);
        supplyLow <= 1'b0;
        waitPin(1'b1, 15, 70);
        results();
    end
endmodule
`default_nettype wire
